// File: hdl/diei_pkg.sv
// Purpose: Shared constants of the digital input edge interrupt block.
// Assumes: A 32-bit classic Wishbone register bus and a 200 MHz clock.
// Notes: Offsets are byte addresses of aligned 32-bit words.
package diei_pkg;
	////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SEL_W = 4;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned NUM_INPUTS = 24;
	localparam int unsigned CNT_W = 16;
	////////////////////////////////////////////////////////////////////////
	// Register offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_RISE_STATUS = 8'h04;
	localparam logic [7:0] OFS_FALL_STATUS = 8'h08;
	localparam logic [7:0] OFS_RISE_ENABLE = 8'h0c;
	localparam logic [7:0] OFS_FALL_ENABLE = 8'h10;
	localparam logic [7:0] OFS_RISE_CLEAR = 8'h14;
	localparam logic [7:0] OFS_FALL_CLEAR = 8'h18;
	localparam logic [7:0] OFS_INPUT_STATE = 8'h1c;
	localparam logic [7:0] OFS_RISE_SET = 8'h20;
	localparam logic [7:0] OFS_FALL_SET = 8'h24;
	localparam logic [7:0] OFS_OVERRUN = 8'h28;
	////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int unsigned CTRL_MASTER_BIT = 0;
	localparam int unsigned OVR_RISE_BIT = 0;
	localparam int unsigned OVR_FALL_BIT = 1;
	////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [31:0] RST_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] RST_STATUS = 32'h0000_0000;
	localparam logic [1:0] RST_OVERRUN = 2'h0;
	////////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int unsigned CLK_FREQ_MHZ = 200;
	localparam int unsigned MOTION_CYCLE_NS = 1000;
	localparam int unsigned MOTION_CYCLE_CLKS =
		(MOTION_CYCLE_NS * CLK_FREQ_MHZ) / 1000;
endpackage : diei_pkg

// File: hdl/diei_sampler.sv
// Purpose: Motion cycle sampler and edge detector for the digital inputs.
// Assumes: Inputs are asynchronous pins.
// Notes: The first sample after reset only primes the comparison.
`timescale 1ns/1ps
`default_nettype none
module diei_sampler #(
	parameter int unsigned N = diei_pkg::NUM_INPUTS,
	parameter int unsigned CYCLE_CLKS = diei_pkg::MOTION_CYCLE_CLKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [N-1:0] din_i,
	output logic [N-1:0] state_o,
	output logic [N-1:0] rise_o,
	output logic [N-1:0] fall_o
);
	localparam logic [diei_pkg::CNT_W-1:0] LAST =
		diei_pkg::CNT_W'(CYCLE_CLKS - 1);
	logic [N-1:0] sync1_q;
	logic [N-1:0] sync2_q;
	logic [diei_pkg::CNT_W-1:0] cnt_q;
	logic primed_q;
	wire tick = (cnt_q == LAST);
	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= din_i;
			sync2_q <= sync1_q;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Once per cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Compare with previous sample.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_o <= '0;
			primed_q <= 1'b0;
			rise_o <= '0;
			fall_o <= '0;
		end else if (tick) begin
			state_o <= sync2_q;
			primed_q <= 1'b1;
			rise_o <= primed_q ? (sync2_q & ~state_o) : '0;
			fall_o <= primed_q ? (~sync2_q & state_o) : '0;
		end else begin
			rise_o <= '0;
			fall_o <= '0;
		end
	end
endmodule : diei_sampler
`default_nettype wire

// File: hdl/diei_event_bank.sv
// Purpose: Sticky signaled event bits of one interrupt item.
// Assumes: All inputs are on the block clock.
// Notes: An enabled set in the cycle of a clear wins.
`timescale 1ns/1ps
`default_nettype none
module diei_event_bank #(
	parameter int unsigned W = diei_pkg::NUM_INPUTS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] event_i,
	input wire logic [W-1:0] enable_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] status_o,
	output logic overrun_o
);
	wire [W-1:0] fire = (event_i | set_i) & enable_i;
	////////////////////////////////////////////////////////////////////////
	// Latch until cleared.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_o <= diei_pkg::RST_STATUS[W-1:0];
			overrun_o <= 1'b0;
		end else begin
			status_o <= (status_o & ~clr_i) | fire;
			overrun_o <= |(event_i & enable_i & status_o & ~clr_i);
		end
	end
endmodule : diei_event_bank
`default_nettype wire

// File: hdl/diei_top.sv
// Purpose: Digital input edge interrupt controller with a Wishbone slave.
// Assumes: Classic Wishbone, 32-bit data, byte addresses on wb_adr_i.
// Notes: Event bits 0 to 23 follow inputs 0 to 23; higher bits read zero.
// Function
// - Falling item has bits 0-23, bits 0-23 are inputs 0-23.
// - Every input sampled once per motion cycle, compared with prior sample.
// - Interrupt reaches the host only while master enable is set.
// - Each factor has its own enable; only enabled factors signal.
// - An enabled event stays signaled until the host clears it.
// - A still signaled event keeps the interrupt up at once while its enable is set.
// - Separate rising and falling items with the same bit mapping.
// - Every item is a 32-bit word, unused bits read zero.
`timescale 1ns/1ps
`default_nettype none
module diei_top #(
	parameter int unsigned NUM_INPUTS = diei_pkg::NUM_INPUTS,
	parameter int unsigned CYCLE_CLKS = diei_pkg::MOTION_CYCLE_CLKS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [diei_pkg::ADDR_W-1:0] wb_adr_i,
	input wire logic [diei_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [diei_pkg::DATA_W-1:0] wb_dat_i,
	output logic [diei_pkg::DATA_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [NUM_INPUTS-1:0] din_i,
	output logic irq_o
);
	localparam int unsigned N = NUM_INPUTS;
	localparam int unsigned DW = diei_pkg::DATA_W;
	localparam int unsigned PAD = DW - N;
	////////////////////////////////////////////////////////////////////////
	// Byte enables expanded to a bit mask.
	function automatic logic [DW-1:0] diei_mask(
		input logic [diei_pkg::SEL_W-1:0] sel
	);
		logic [DW-1:0] m;
		m = '0;
		for (int b = 0; b < diei_pkg::SEL_W; b++) begin
			m[b*8 +: 8] = {8{sel[b]}};
		end
		return m;
	endfunction : diei_mask
	////////////////////////////////////////////////////////////////////////
	// Address match on the word index.
	function automatic logic diei_hit(
		input logic [diei_pkg::ADDR_W-1:0] adr,
		input logic [7:0] ofs
	);
		return adr[diei_pkg::ADDR_W-1:2] == ofs[diei_pkg::ADDR_W-1:2];
	endfunction : diei_hit
	////////////////////////////////////////////////////////////////////////
	// Register state.
	logic ctrl_master_q;
	logic [N-1:0] rise_en_q;
	logic [N-1:0] fall_en_q;
	logic [1:0] ovr_q;
	logic [DW-1:0] dat_q;
	logic ack_q;
	logic err_q;
	logic irq_q;
	logic [N-1:0] in_state;
	logic [N-1:0] rise_evt;
	logic [N-1:0] fall_evt;
	logic [N-1:0] rise_status;
	logic [N-1:0] fall_status;
	logic rise_ovr;
	logic fall_ovr;
	////////////////////////////////////////////////////////////////////////
	// Bus decode.
	wire access = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
	wire wr = access & wb_we_i;
	wire [DW-1:0] bmask = diei_mask(wb_sel_i);
	wire [DW-1:0] wmask_dat = wb_dat_i & bmask;
	wire hit_ctrl = diei_hit(wb_adr_i, diei_pkg::OFS_CTRL);
	wire hit_rstat = diei_hit(wb_adr_i, diei_pkg::OFS_RISE_STATUS);
	wire hit_fstat = diei_hit(wb_adr_i, diei_pkg::OFS_FALL_STATUS);
	wire hit_ren = diei_hit(wb_adr_i, diei_pkg::OFS_RISE_ENABLE);
	wire hit_fen = diei_hit(wb_adr_i, diei_pkg::OFS_FALL_ENABLE);
	wire hit_rclr = diei_hit(wb_adr_i, diei_pkg::OFS_RISE_CLEAR);
	wire hit_fclr = diei_hit(wb_adr_i, diei_pkg::OFS_FALL_CLEAR);
	wire hit_state = diei_hit(wb_adr_i, diei_pkg::OFS_INPUT_STATE);
	wire hit_rset = diei_hit(wb_adr_i, diei_pkg::OFS_RISE_SET);
	wire hit_fset = diei_hit(wb_adr_i, diei_pkg::OFS_FALL_SET);
	wire hit_ovr = diei_hit(wb_adr_i, diei_pkg::OFS_OVERRUN);
	wire hit_any = hit_ctrl | hit_rstat | hit_fstat | hit_ren | hit_fen |
		hit_rclr | hit_fclr | hit_state | hit_rset | hit_fset | hit_ovr;
	////////////////////////////////////////////////////////////////////////
	// Write strobes for the enable and pulse registers.
	wire [N-1:0] ren_d =
		(rise_en_q & ~bmask[N-1:0]) | wmask_dat[N-1:0];
	wire [N-1:0] fen_d =
		(fall_en_q & ~bmask[N-1:0]) | wmask_dat[N-1:0];
	wire ctrl_wr = wr & hit_ctrl & wb_sel_i[0];
	wire [N-1:0] rise_clr = (wr && hit_rclr) ? wmask_dat[N-1:0] : '0;
	wire [N-1:0] fall_clr = (wr && hit_fclr) ? wmask_dat[N-1:0] : '0;
	wire [N-1:0] rise_set = (wr && hit_rset) ? wmask_dat[N-1:0] : '0;
	wire [N-1:0] fall_set = (wr && hit_fset) ? wmask_dat[N-1:0] : '0;
	wire [1:0] ovr_clr = (wr && hit_ovr) ? wmask_dat[1:0] : 2'h0;
	wire [1:0] ovr_set = {fall_ovr, rise_ovr};
	////////////////////////////////////////////////////////////////////////
	// Master switch.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_master_q <= diei_pkg::RST_CTRL[diei_pkg::CTRL_MASTER_BIT];
		end else if (ctrl_wr) begin
			ctrl_master_q <= wb_dat_i[diei_pkg::CTRL_MASTER_BIT];
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Factor enables.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rise_en_q <= diei_pkg::RST_ENABLE[N-1:0];
			fall_en_q <= diei_pkg::RST_ENABLE[N-1:0];
		end else begin
			if (wr && hit_ren) begin
				rise_en_q <= ren_d;
			end
			if (wr && hit_fen) begin
				fall_en_q <= fen_d;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Overrun flags, a new occurrence wins over the clear.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ovr_q <= diei_pkg::RST_OVERRUN;
		end else begin
			ovr_q <= (ovr_q & ~ovr_clr) | ovr_set;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Input sampling.
	diei_sampler #(
		.N(N),
		.CYCLE_CLKS(CYCLE_CLKS)
	) u_sampler (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.din_i(din_i),
		.state_o(in_state),
		.rise_o(rise_evt),
		.fall_o(fall_evt)
	);
	////////////////////////////////////////////////////////////////////////
	// Rising edge item.
	diei_event_bank #(
		.W(N)
	) u_rise_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(rise_evt),
		.enable_i(rise_en_q),
		.set_i(rise_set),
		.clr_i(rise_clr),
		.status_o(rise_status),
		.overrun_o(rise_ovr)
	);
	////////////////////////////////////////////////////////////////////////
	// Falling edge item.
	diei_event_bank #(
		.W(N)
	) u_fall_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(fall_evt),
		.enable_i(fall_en_q),
		.set_i(fall_set),
		.clr_i(fall_clr),
		.status_o(fall_status),
		.overrun_o(fall_ovr)
	);
	////////////////////////////////////////////////////////////////////////
	// Read data zero padded.
	wire [DW-1:0] rd_ctrl = {{(DW-1){1'b0}}, ctrl_master_q};
	wire [DW-1:0] rd_rstat = {{PAD{1'b0}}, rise_status};
	wire [DW-1:0] rd_fstat = {{PAD{1'b0}}, fall_status};
	wire [DW-1:0] rd_ren = {{PAD{1'b0}}, rise_en_q};
	wire [DW-1:0] rd_fen = {{PAD{1'b0}}, fall_en_q};
	wire [DW-1:0] rd_state = {{PAD{1'b0}}, in_state};
	wire [DW-1:0] rd_ovr = {{(DW-2){1'b0}}, ovr_q};
	wire [DW-1:0] rd_data =
		hit_ctrl ? rd_ctrl :
		hit_rstat ? rd_rstat :
		hit_fstat ? rd_fstat :
		hit_ren ? rd_ren :
		hit_fen ? rd_fen :
		hit_state ? rd_state :
		hit_ovr ? rd_ovr : '0;
	////////////////////////////////////////////////////////////////////////
	// Bus answer, error on an unmapped word.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			dat_q <= '0;
		end else begin
			ack_q <= access & hit_any;
			err_q <= access & ~hit_any;
			dat_q <= (access && !wb_we_i) ? rd_data : '0;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Gate by master enable.
	// A signaled bit keeps the line up while its enable is set.
	wire pending = |(rise_status & rise_en_q) | |(fall_status & fall_en_q);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= ctrl_master_q & pending;
		end
	end
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign irq_o = irq_q;
endmodule : diei_top
`default_nettype wire

// File: verification/diei_top_chk.sv
// Purpose: Port checker for the edge interrupt block.
// Assumes: One clock, synchronous active high reset.
// Notes: Bound to every diei_top instance.
`timescale 1ns/1ps
`default_nettype none
module diei_top_chk #(
	parameter int unsigned NUM_INPUTS = 24,
	parameter int unsigned CYCLE_CLKS = 200
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [NUM_INPUTS-1:0] din_i,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence answer_s;
		##1 (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	sequence ctrl_off_s;
		take_s ##0 (wb_we_i && wb_sel_i[0] && !wb_dat_i[0] &&
			wb_adr_i[7:2] == 6'h00);
	endsequence
	answer_once_a: assert property (take_s |-> answer_s)
		else $error("bus request not answered once");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	resp_excl_a: assert property (!(wb_ack_o && wb_err_o))
		else $error("ack and err together");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	hi_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:24] == 8'h00)
		else $error("unused bits not zero");
	unmapped_err_a: assert property (take_s and wb_adr_i > 8'h2b |=> wb_err_o)
		else $error("unmapped access not refused");
	master_off_a: assert property (ctrl_off_s |-> ##2 !irq_o [*2])
		else $error("interrupt with master off");
	irq_sticky_a: assert property ($fell(irq_o) |->
		$past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2))
		else $error("interrupt dropped without host write");
endmodule : diei_top_chk
bind diei_top diei_top_chk #(.NUM_INPUTS(NUM_INPUTS), .CYCLE_CLKS(CYCLE_CLKS))
	diei_top_chk_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
	.din_i, .irq_o);
`default_nettype wire

// File: verification/diei_host.sv
// Purpose: Host processor model issuing classic Wishbone cycles.
// Assumes: One request at a time, issued right after a rising edge.
// Notes: The bench orders clear and shutdown writes through it.
`timescale 1ns/1ps
`default_nettype none
module diei_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic err_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0;
	end
	task automatic xfer(input logic we, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= we;
		adr_o <= a;
		sel_o <= s;
		dat_o <= d;
		do @(posedge clk_i); while (!(ack_i || err_i));
		q = dat_i;
		e = err_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= ~we;
		adr_o <= ~a;
		sel_o <= ~s;
		dat_o <= ~d;
		@(posedge clk_i);
	endtask : xfer
endmodule : diei_host
`default_nettype wire

// File: verification/diei_top_tb.sv
// Purpose: Self-checking bench for the edge interrupt block.
// Assumes: Motion cycle shortened to four clocks.
// Notes: Input changes stay slower than one motion cycle.
`timescale 1ns/1ps
`default_nettype none
module diei_top_tb;
	logic clk_i, rst_i, cyc, stb, we, ack, err, irq_o;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [23:0] din_q;
	int bad_count = 0;
	int tests_run = 0;
	diei_top #(.CYCLE_CLKS(4)) diei_top_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.wb_err_o(err), .din_i(din_q), .irq_o(irq_o));
	diei_host diei_host_inst (.clk_i(clk_i), .ack_i(ack), .err_i(err),
		.dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat));
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wrs(input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		logic [31:0] q;
		logic e;
		diei_host_inst.xfer(1'b1, a, s, d, q, e);
	endtask : wrs
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wrs(a, 4'hf, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] q;
		logic e;
		diei_host_inst.xfer(1'b0, a, 4'hf, 32'h0, q, e);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask : rd
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int a = 0; a < 11; a++) rd(8'(a * 4), 32'h0, 1'b0);
		rd(8'h2c, 32'h0, 1'b1);
		wr(diei_pkg::OFS_FALL_STATUS, 32'hffff_ffff);
		wr(diei_pkg::OFS_FALL_SET, 32'h0000_0001);
		rd(diei_pkg::OFS_FALL_STATUS, 32'h0, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_rise;
		wr(diei_pkg::OFS_RISE_ENABLE, 32'h0080_0001);
		wr(diei_pkg::OFS_CTRL, 32'h1);
		din_q <= 24'h80_0103;
		tick(20);
		rd(diei_pkg::OFS_RISE_STATUS, 32'h0080_0001, 1'b0);
		rd(diei_pkg::OFS_FALL_STATUS, 32'h0, 1'b0);
		rd(diei_pkg::OFS_INPUT_STATE, 32'h0080_0103, 1'b0);
		chk({31'h0, irq_o}, 32'h1);
		tick(20);
		chk({31'h0, irq_o}, 32'h1);
		wr(diei_pkg::OFS_RISE_CLEAR, 32'h0080_0001);
		tick(3);
		chk({31'h0, irq_o}, 32'h0);
		rd(diei_pkg::OFS_RISE_STATUS, 32'h0, 1'b0);
		wr(diei_pkg::OFS_RISE_ENABLE, 32'h0);
		$display("test rise done");
	endtask : t_rise
	task automatic t_fall;
		wr(diei_pkg::OFS_CTRL, 32'h0);
		wr(diei_pkg::OFS_FALL_ENABLE, 32'h0000_0100);
		din_q <= 24'h00_0000;
		tick(20);
		chk({31'h0, irq_o}, 32'h0);
		rd(diei_pkg::OFS_FALL_STATUS, 32'h0000_0100, 1'b0);
		wr(diei_pkg::OFS_CTRL, 32'h1);
		tick(3);
		chk({31'h0, irq_o}, 32'h1);
		wr(diei_pkg::OFS_FALL_ENABLE, 32'h0);
		wr(diei_pkg::OFS_CTRL, 32'h0);
		wr(diei_pkg::OFS_FALL_CLEAR, 32'h0000_0100);
		tick(3);
		chk({31'h0, irq_o}, 32'h0);
		rd(diei_pkg::OFS_FALL_STATUS, 32'h0, 1'b0);
		$display("test fall done");
	endtask : t_fall
	task automatic t_over;
		wrs(diei_pkg::OFS_CTRL, 4'he, 32'h0000_0001);
		rd(diei_pkg::OFS_CTRL, 32'h0, 1'b0);
		wrs(diei_pkg::OFS_RISE_ENABLE, 4'h1, 32'hffff_ff04);
		rd(diei_pkg::OFS_RISE_ENABLE, 32'h0000_0004, 1'b0);
		wr(diei_pkg::OFS_RISE_SET, 32'h0000_0006);
		rd(diei_pkg::OFS_RISE_STATUS, 32'h0000_0004, 1'b0);
		din_q <= 24'h00_0004;
		tick(20);
		rd(diei_pkg::OFS_INPUT_STATE, 32'h0000_0004, 1'b0);
		rd(diei_pkg::OFS_OVERRUN, 32'h0000_0001, 1'b0);
		chk({31'h0, irq_o}, 32'h0);
		wr(diei_pkg::OFS_OVERRUN, 32'h0000_0001);
		wr(diei_pkg::OFS_RISE_CLEAR, 32'h0000_0004);
		rd(diei_pkg::OFS_OVERRUN, 32'h0, 1'b0);
		rd(diei_pkg::OFS_RISE_STATUS, 32'h0, 1'b0);
		wr(diei_pkg::OFS_RISE_ENABLE, 32'h0);
		$display("test overrun done");
	endtask : t_over
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	initial begin
		repeat (4000) @(posedge clk_i);
		bad_count++;
		end_of_test();
	end
	initial begin
		rst_i = 1'b1;
		din_q = 24'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		tick(12);
		t_reset();
		t_rise();
		t_fall();
		t_over();
		end_of_test();
	end
endmodule : diei_top_tb
`default_nettype wire
